// *** logic/ext_bus_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module ext_bus_ctrl
    import ext_bus_pkg::*;
#(
    parameter int SLOT_CYCLES = SLOT_CYCLES_DEF
)
(
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        external_fetch_select_n_i,
    input  wire logic        program_fetch_strobe_n_i,
    output var  logic        program_fetch_strobe_n_o,
    output var  logic        program_fetch_strobe_n_oe_o,
    output var  logic        address_latch_strobe_o,
    output var  logic        read_strobe_n_o,
    output var  logic        write_strobe_n_o,
    input  wire logic [7:0]  muxed_address_data_port_i,
    output var  logic [7:0]  muxed_address_data_port_o,
    output var  logic [7:0]  muxed_address_data_port_oe_o,
    output var  logic [7:0]  upper_address_port_o,
    input  wire logic [7:0]  port_latch_i,
    input  wire logic [15:0] fetch_addr_i,
    output var  logic        fetch_done_o,
    output var  logic        fetch_external_o,
    output var  logic [7:0]  fetch_data_o,
    input  wire logic        xdata_req_i,
    input  wire logic        xdata_write_i,
    input  wire logic        xdata_wide_i,
    input  wire logic [23:0] xdata_addr_i,
    input  wire logic [7:0]  xdata_wdata_i,
    output var  logic        xdata_ack_o,
    output var  logic [7:0]  xdata_rdata_o,
    output var  logic        serial_download_o
);
    localparam int PW = $clog2(SLOT_CYCLES);
    localparam logic [PW-1:0] PH_LAST   = PW'(SLOT_CYCLES - 1);
    localparam logic [PW-1:0] PH_ALE    = PW'(ALE_LAST_PHASE);
    localparam logic [PW-1:0] PH_ADDR   = PW'(ADDR_LAST_PHASE);
    localparam logic [PW-1:0] PH_STROBE = PW'(STROBE_FIRST_PHASE);
    localparam logic [PW-1:0] PH_CAP    = PW'(ALE_LAST_PHASE);

    // refuse slot lengths the phase layout cannot serve
    if (SLOT_CYCLES < SLOT_MIN_CYCLES)
    begin
        $error("SLOT_CYCLES too small for the slot phase layout");
    end

    logic          sel_meta_q, sel_sync_q;
    logic          fstb_meta_q, fstb_sync_q;
    logic [7:0]    port_meta_q, port_sync_q;
    logic [1:0]    start_cnt_q;
    logic          download_q;
    logic [PW-1:0] phase_q;
    bus_kind_type  kind_q, kind_d;
    logic [23:0]   addr_q;
    logic [7:0]    wdata_q;
    logic          write_q, wide_q;
    bus_kind_type  cap_kind_q;
    logic          cap_q;
    logic          slot_end;

    assign slot_end = (phase_q == PH_LAST);

    // two-stage synchronisers for pin inputs
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sel_meta_q  <= 1'b1;
            sel_sync_q  <= 1'b1;
            fstb_meta_q <= 1'b1;
            fstb_sync_q <= 1'b1;
            port_meta_q <= PORT_RESET;
            port_sync_q <= PORT_RESET;
        end
        else
        begin
            sel_meta_q  <= external_fetch_select_n_i;
            sel_sync_q  <= sel_meta_q;
            fstb_meta_q <= program_fetch_strobe_n_i;
            fstb_sync_q <= fstb_meta_q;
            port_meta_q <= muxed_address_data_port_i;
            port_sync_q <= port_meta_q;
        end
    end

    // sample the fetch strobe pin once the synchroniser has filled
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            start_cnt_q <= STARTUP_CYCLES;
            download_q  <= 1'b0;
        end
        else if (start_cnt_q != 2'h0)
        begin
            start_cnt_q <= start_cnt_q - 2'h1;
            if (start_cnt_q == STARTUP_SAMPLE)
                download_q <= !fstb_sync_q;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            phase_q <= '0;
        else if (slot_end)
            phase_q <= '0;
        else
            phase_q <= phase_q + PW'(1);
    end

    // slot scheduler: a data access takes an address slot then a
    // transfer slot; a fetch slot always follows a transfer
    always_comb
    begin
        if (start_cnt_q != 2'h0 || download_q)
            kind_d = KIND_HALT;
        else if (kind_q == KIND_DATA_ADDR)
            kind_d = KIND_DATA_XFER;
        else if (xdata_req_i && kind_q != KIND_DATA_XFER)
            kind_d = KIND_DATA_ADDR;
        else if (sel_sync_q && fetch_addr_i <= INT_CODE_LAST)
            kind_d = KIND_FETCH_INT;
        else
            kind_d = KIND_FETCH_EXT;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            kind_q  <= KIND_HALT;
            addr_q  <= ADDR_RESET;
            wdata_q <= BYTE_RESET;
            write_q <= 1'b0;
            wide_q  <= 1'b0;
        end
        else if (slot_end)
        begin
            kind_q <= kind_d;
            if (kind_d == KIND_DATA_ADDR)
            begin
                addr_q  <= xdata_addr_i;
                wdata_q <= xdata_wdata_i;
                write_q <= xdata_write_i;
                wide_q  <= xdata_wide_i;
            end
            else if (kind_d != KIND_DATA_XFER)
            begin
                addr_q  <= {8'h00, fetch_addr_i};
                wide_q  <= 1'b0;
            end
        end
    end

    // strobes, registered from the current slot and phase
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            address_latch_strobe_o      <= 1'b0;
            program_fetch_strobe_n_o    <= 1'b1;
            program_fetch_strobe_n_oe_o <= 1'b0;
            read_strobe_n_o             <= 1'b1;
            write_strobe_n_o            <= 1'b1;
        end
        else
        begin
            address_latch_strobe_o <= (kind_q == KIND_FETCH_INT
                || kind_q == KIND_FETCH_EXT
                || kind_q == KIND_DATA_ADDR)
                && phase_q <= PH_ALE;
            program_fetch_strobe_n_o <= !(kind_q == KIND_FETCH_EXT
                && phase_q >= PH_STROBE);
            program_fetch_strobe_n_oe_o <= (kind_q != KIND_HALT);
            read_strobe_n_o <= !(kind_q == KIND_DATA_XFER && !write_q
                && phase_q >= PH_STROBE);
            write_strobe_n_o <= !(kind_q == KIND_DATA_XFER && write_q
                && phase_q >= PH_STROBE);
        end
    end

    // muxed port and upper address port
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            muxed_address_data_port_o    <= BYTE_RESET;
            muxed_address_data_port_oe_o <= OE_NONE;
            upper_address_port_o         <= PORT_RESET;
        end
        else
        begin
            if ((kind_q == KIND_FETCH_EXT && phase_q <= PH_ADDR)
                || kind_q == KIND_DATA_ADDR)
            begin
                muxed_address_data_port_o    <= addr_q[7:0];
                muxed_address_data_port_oe_o <= OE_ALL;
            end
            else if (kind_q == KIND_DATA_XFER && write_q)
            begin
                muxed_address_data_port_o    <= wdata_q;
                muxed_address_data_port_oe_o <= OE_ALL;
            end
            else if (kind_q == KIND_FETCH_EXT || kind_q == KIND_DATA_XFER)
            begin
                muxed_address_data_port_o    <= BYTE_RESET;
                muxed_address_data_port_oe_o <= OE_NONE;
            end
            else
            begin
                // port mode: open drain, ones float
                muxed_address_data_port_o    <= BYTE_RESET;
                muxed_address_data_port_oe_o <= ~port_latch_i;
            end
            if (kind_q == KIND_DATA_ADDR && wide_q && phase_q <= PH_ALE)
                upper_address_port_o <= addr_q[23:16];
            else if (kind_q != KIND_HALT)
                upper_address_port_o <= addr_q[15:8];
        end
    end

    // capture read data once the synchroniser shows the strobed bus
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cap_q            <= 1'b0;
            cap_kind_q       <= KIND_HALT;
            fetch_done_o     <= 1'b0;
            fetch_external_o <= 1'b0;
            fetch_data_o     <= BYTE_RESET;
            xdata_ack_o      <= 1'b0;
            xdata_rdata_o    <= BYTE_RESET;
        end
        else
        begin
            fetch_done_o <= 1'b0;
            xdata_ack_o  <= 1'b0;
            if (slot_end)
            begin
                cap_q      <= kind_q != KIND_HALT
                              && kind_q != KIND_DATA_ADDR;
                cap_kind_q <= kind_q;
            end
            else if (cap_q && phase_q == PH_CAP)
            begin
                cap_q <= 1'b0;
                if (cap_kind_q == KIND_DATA_XFER)
                begin
                    xdata_ack_o <= 1'b1;
                    if (!write_q)
                        xdata_rdata_o <= port_sync_q;
                end
                else
                begin
                    fetch_done_o     <= 1'b1;
                    fetch_external_o <= (cap_kind_q == KIND_FETCH_EXT);
                    if (cap_kind_q == KIND_FETCH_EXT)
                        fetch_data_o <= port_sync_q;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            serial_download_o <= 1'b0;
        else
            serial_download_o <= download_q;
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    a_fetch_pulse_width: assert property (
        $fell(program_fetch_strobe_n_o) |->
            !program_fetch_strobe_n_o [*3] ##1 program_fetch_strobe_n_o)
        else $error("fetch strobe pulse not three cycles");
    a_fetch_not_in_data: assert property (
        (!read_strobe_n_o || !write_strobe_n_o) |->
            program_fetch_strobe_n_o)
        else $error("fetch strobe active during data access");
    a_fetch_internal_high: assert property (
        kind_q == KIND_FETCH_INT |=> program_fetch_strobe_n_o)
        else $error("fetch strobe low during internal fetch");
    a_download_quiet: assert property (
        download_q |=> !program_fetch_strobe_n_oe_o
            && !address_latch_strobe_o && read_strobe_n_o)
        else $error("bus active in download mode");
    a_ale_quiet_xfer: assert property (
        (!read_strobe_n_o || !write_strobe_n_o) |->
            !address_latch_strobe_o)
        else $error("latch strobe during data transfer");
    a_ale_two_cycles: assert property (
        $rose(address_latch_strobe_o) |->
            address_latch_strobe_o [*2] ##1 !address_latch_strobe_o)
        else $error("latch strobe width wrong");
    a_fetch_source: assert property (
        kind_q == KIND_FETCH_INT |-> sel_sync_q
            && addr_q[15:0] <= INT_CODE_LAST)
        else $error("internal fetch outside its range");
    a_ext_fetch_strobe: assert property (
        kind_q == KIND_FETCH_EXT && phase_q == PH_STROBE |=>
            !program_fetch_strobe_n_o ##3 program_fetch_strobe_n_o)
        else $error("external fetch without fetch strobe");
    a_port_open_drain: assert property (
        kind_q == KIND_FETCH_INT |=>
            muxed_address_data_port_oe_o == ~$past(port_latch_i)
            && muxed_address_data_port_o == BYTE_RESET)
        else $error("port mode drives a released bit");
    a_addr_drive_ones: assert property (
        kind_q == KIND_DATA_ADDR && phase_q == '0 |=>
            muxed_address_data_port_oe_o == OE_ALL
            && muxed_address_data_port_o == $past(addr_q[7:0]))
        else $error("address byte not driven on muxed port");
    a_upper_page: assert property (
        kind_q == KIND_DATA_ADDR && wide_q && phase_q == '0 |=>
            upper_address_port_o == $past(addr_q[23:16])
            ##3 upper_address_port_o == addr_q[15:8])
        else $error("page byte sequence wrong");
    a_addr_held_at_fall: assert property (
        $fell(address_latch_strobe_o)
            && muxed_address_data_port_oe_o == OE_ALL |->
            $stable(muxed_address_data_port_o))
        else $error("address changed as latch strobe fell");
    a_strobe_after_ale: assert property (
        ($fell(program_fetch_strobe_n_o) || $fell(read_strobe_n_o)
            || $fell(write_strobe_n_o)) |-> $past(!address_latch_strobe_o))
        else $error("strobe overlaps latch strobe");
    a_write_data: assert property (
        !write_strobe_n_o |-> muxed_address_data_port_oe_o == OE_ALL
            && muxed_address_data_port_o == wdata_q)
        else $error("write data not on port");
    a_read_release: assert property (
        !read_strobe_n_o |-> muxed_address_data_port_oe_o == OE_NONE)
        else $error("port driven during read");

    c_ext_fetch:  cover property (fetch_done_o && fetch_external_o);
    c_data_write: cover property ($fell(write_strobe_n_o));
    c_data_read:  cover property (xdata_ack_o && !write_q);
    c_download:   cover property ($rose(serial_download_o));
endmodule
`default_nettype wire

// *** logic/ext_bus_pkg.sv ***
`default_nettype none
package ext_bus_pkg;
    // slot timing: six oscillator periods per bus slot
    localparam int OSC_PERIOD_NS   = 8;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int SLOT_PERIODS    = 6;
    localparam int SLOT_CYCLES_DEF = (SLOT_PERIODS * OSC_PERIOD_NS)
                                     / CLK_PERIOD_NS;
    // phase layout inside one slot
    localparam int ALE_LAST_PHASE     = 1;
    localparam int ADDR_LAST_PHASE    = 2;
    localparam int STROBE_FIRST_PHASE = 3;
    localparam int SLOT_MIN_CYCLES    = 6;
    // start-up sampling of the fetch strobe pin
    localparam logic [1:0] STARTUP_CYCLES = 2'h3;
    localparam logic [1:0] STARTUP_SAMPLE = 2'h1;
    // internal code range
    localparam logic [15:0] INT_CODE_LAST = 16'h1FFF;
    // reset values and port enable masks
    localparam logic [7:0]  PORT_RESET  = 8'hFF;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [7:0]  OE_ALL      = 8'hFF;
    localparam logic [7:0]  OE_NONE     = 8'h00;
    localparam logic [23:0] ADDR_RESET  = 24'h000000;

    typedef enum logic [2:0] {
        KIND_HALT,
        KIND_FETCH_INT,
        KIND_FETCH_EXT,
        KIND_DATA_ADDR,
        KIND_DATA_XFER
    } bus_kind_type;
endpackage
`default_nettype wire

// *** sim/ext_memory_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model
(
    input  wire logic        mclk_i,
    input  wire logic        ale_i,
    input  wire logic        fetch_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [7:0]  port_i,
    input  wire logic [7:0]  upper_i,
    output logic             drive_o,
    output logic [7:0]       data_o,
    output logic [31:0]      wr_rec_o
);
    logic [7:0] lo_q;
    logic [7:0] page_q;
    logic       idle_q = 1'b1;

    // external latch takes low byte, upper port gives page
    always_ff @(posedge mclk_i)
    begin
        if (ale_i)
        begin
            lo_q   <= port_i;
            page_q <= upper_i;
        end
    end

    // read data held one cycle past the strobe
    always_ff @(posedge mclk_i)
    begin
        idle_q <= fetch_n_i & rd_n_i;
        if (!(fetch_n_i & rd_n_i))
            data_o <= lo_q ^ {upper_i[3:0], upper_i[7:4]};
    end

    assign drive_o = !(fetch_n_i & rd_n_i) || !idle_q;

    // write keeps page, middle, low and data bytes
    always_ff @(posedge mclk_i)
    begin
        if (!wr_n_i)
            wr_rec_o <= {page_q, upper_i, lo_q, port_i};
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ext_bus_pkg::*;
    logic        mclk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        sel_n = 1'b0;
    logic        pull_low = 1'b0;
    logic [7:0]  latch = 8'h00;
    logic [15:0] faddr = 16'h0000;
    logic        req = 1'b0;
    logic        wr = 1'b0;
    logic        wide = 1'b0;
    logic [23:0] xaddr = 24'h000000;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  last_q = 8'h00;
    logic        fetch_n, fetch_oe, ale, rd_n, wr_n, done, f_ext, ack, dl;
    logic        mem_drive;
    logic [7:0]  port_o, port_oe, upper, f_data, rdata, mem_data, pin;
    logic [31:0] wr_rec;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          alen, psf, psl, badbus, badport;

    always #4 mclk_i = ~mclk_i;
    // released port shows a changing pattern, not the last value
    assign pin = (port_oe & port_o)
               | (~port_oe & (mem_drive ? mem_data : ~last_q));
    always_ff @(posedge mclk_i) last_q <= pin;

    ext_bus_ctrl dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i),
        .external_fetch_select_n_i(sel_n),
        .program_fetch_strobe_n_i(fetch_oe ? fetch_n : !pull_low),
        .program_fetch_strobe_n_o(fetch_n),
        .program_fetch_strobe_n_oe_o(fetch_oe),
        .address_latch_strobe_o(ale), .read_strobe_n_o(rd_n),
        .write_strobe_n_o(wr_n), .muxed_address_data_port_i(pin),
        .muxed_address_data_port_o(port_o),
        .muxed_address_data_port_oe_o(port_oe),
        .upper_address_port_o(upper), .port_latch_i(latch),
        .fetch_addr_i(faddr), .fetch_done_o(done),
        .fetch_external_o(f_ext), .fetch_data_o(f_data),
        .xdata_req_i(req), .xdata_write_i(wr), .xdata_wide_i(wide),
        .xdata_addr_i(xaddr), .xdata_wdata_i(wdata),
        .xdata_ack_o(ack), .xdata_rdata_o(rdata), .serial_download_o(dl));

    ext_memory_model mem (
        .mclk_i(mclk_i), .ale_i(ale), .fetch_n_i(fetch_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .port_i(port_o), .upper_i(upper),
        .drive_o(mem_drive), .data_o(mem_data), .wr_rec_o(wr_rec));

    function automatic logic [7:0] mix(input logic [7:0] lo, up);
        return lo ^ {up[3:0], up[7:4]};
    endfunction

    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wait_on(input bit on_ack);
        for (int i = 0; i < 200; i++)
        begin
            @(negedge mclk_i);
            if ((on_ack ? ack : done) === 1'b1)
                return;
        end
        num_errors++;
        summarize();
    endtask

    task automatic do_reset(input logic low);
        @(posedge mclk_i);
        nrst_i   <= 1'b0;
        pull_low <= low;
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
    endtask

    // ten slots of strobes, with bus-mode and port-mode pin checks
    task automatic window(input logic [7:0] lo, input logic [7:0] hi);
        logic ale_p, ps_p;
        ale_p = ale;
        ps_p = fetch_n;
        alen = 0;
        psf = 0;
        psl = 0;
        badbus = 0;
        badport = 0;
        repeat (60)
        begin
            @(negedge mclk_i);
            alen += int'(ale && !ale_p);
            psf += int'(!fetch_n && ps_p);
            psl += int'(!fetch_n);
            badbus += int'(ale
                && {port_oe, port_o, upper} !== {8'hFF, lo, hi});
            badport += int'(!ale && port_oe !== ~latch);
            ale_p = ale;
            ps_p = fetch_n;
        end
    endtask

    task automatic t_ext_fetch();
        @(posedge mclk_i);
        sel_n <= 1'b0;
        faddr <= 16'h3CF5;
        repeat (2) wait_on(1'b0);
        check(f_ext, 1);
        check(f_data, mix(8'hF5, 8'h3C));
        window(8'hF5, 8'h3C);
        check(alen, 10);
        check(psf, 10);
        check(badbus, 0);
    endtask

    task automatic t_int_fetch();
        @(posedge mclk_i);
        sel_n <= 1'b1;
        faddr <= 16'h1FFF;
        latch <= 8'h5A;
        repeat (3) wait_on(1'b0);
        check(f_ext, 0);
        window(8'h00, 8'h00);
        check(psl, 0);
        check(alen, 10);
        check(badport, 0);
        @(posedge mclk_i);
        faddr <= 16'h2000;
        repeat (2) wait_on(1'b0);
        check(f_ext, 1);
        check(f_data, mix(8'h00, 8'h20));
    endtask

    task automatic t_xdata(input logic w, input logic wd,
                           input logic [23:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        req <= 1'b1;
        wr <= w;
        wide <= wd;
        xaddr <= a;
        wdata <= d;
        wait_on(1'b1);
        @(posedge mclk_i);
        req <= 1'b0;
        if (w)
            check(wr_rec, {a, d});
        else
            check(rdata, mix(a[7:0], a[15:8]));
    endtask

    task automatic t_download();
        do_reset(1'b1);
        repeat (10) @(negedge mclk_i);
        check(dl, 1);
        check(fetch_oe, 0);
        do_reset(1'b0);
        repeat (10) @(negedge mclk_i);
        check(dl, 0);
    endtask

    initial
    begin
        do_reset(1'b0);
        t_ext_fetch();
        t_xdata(1'b1, 1'b1, 24'h5BC481, 8'hE6);
        t_xdata(1'b1, 1'b1, 24'hFF00FF, 8'h00);
        t_xdata(1'b0, 1'b0, 24'h12A73C, 8'h00);
        t_int_fetch();
        t_download();
        summarize();
    end
endmodule
`default_nettype wire
